// ---- inc/pcr_cfg.svh ----
// Address map, reset values and field positions of the control register bank.
// Assumes the CPU core presents 8-bit data addresses; bank sits at 0xC0-0xFF.
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

`define PCR_A_P0_DATA 8'h00_C0
`define PCR_A_P0_DIR 8'h00_C1
`define PCR_A_P1_DATA 8'h00_C2
`define PCR_A_P1_DIR 8'h00_C3
`define PCR_A_P3_DATA 8'h00_C6
`define PCR_A_P3_DIR 8'h00_C7
`define PCR_A_P0_OD 8'h00_C8
`define PCR_A_P1_OD 8'h00_C9
`define PCR_A_P3_OD 8'h00_CB
`define PCR_A_TM0 8'h00_D0
`define PCR_A_T0 8'h00_D1
`define PCR_A_TM1 8'h00_D2
`define PCR_A_T1PER 8'h00_D3
`define PCR_A_T1 8'h00_D4
`define PCR_A_T1HI 8'h00_D5
`define PCR_A_TM2 8'h00_D6
`define PCR_A_T2 8'h00_D7
`define PCR_A_BUZ 8'h00_E0
`define PCR_A_RPS 8'h00_E1
`define PCR_A_SMC 8'h00_E2
`define PCR_A_SSD 8'h00_E3
`define PCR_A_IEH 8'h00_EA
`define PCR_A_IEL 8'h00_EB
`define PCR_A_IPH 8'h00_EC
`define PCR_A_IPL 8'h00_ED
`define PCR_A_EDGE 8'h00_EE
`define PCR_A_CMC 8'h00_EF
`define PCR_A_CRH 8'h00_F0
`define PCR_A_CRL 8'h00_F1
`define PCR_A_ICK 8'h00_F2
`define PCR_A_WDG 8'h00_F4
`define PCR_A_SSC 8'h00_F5
`define PCR_A_PFD 8'h00_F7
`define PCR_A_PS0 8'h00_F8
`define PCR_A_PS1 8'h00_F9
`define PCR_A_PU0 8'h00_FC
`define PCR_A_PU1 8'h00_FD
`define PCR_A_PU3 8'h00_FF

// Reset values
`define PCR_R_ZERO 8'h00
`define PCR_R_ONES 8'hFF
`define PCR_R_SMC 8'h01
`define PCR_R_CMC 8'h01
`define PCR_R_CKC 8'h17
`define PCR_R_WDG 8'h7F

// Implemented-bit masks; zero bits are reserved and hold no storage
`define PCR_M_IEH 8'hF3
`define PCR_M_IEL 8'hCD
`define PCR_M_RPS 8'h07
`define PCR_M_CKC 8'hBF
`define PCR_M_PFD 8'h07
`define PCR_M_PS0 8'h7F
`define PCR_M_PS1 8'h0F
`define PCR_M_TMX 8'h3F
`define PCR_M_T1HI 8'h0F
`define PCR_M_CRH 8'hE0

// Field positions
`define PCR_B_CAP02 5
`define PCR_B_CAP1 4
`define PCR_B_WDCLR 7
`define PCR_B_ITCLR 3

`endif

// ---- inc/pcr_pkg.sv ----
// Types shared by the control register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package pcr_pkg;
   // Access kind presented by the CPU in a write cycle
   typedef enum logic {
      PCR_ACC_BYTE,
      PCR_ACC_BIT
   } pcr_acc_type;

   // Stored state of the bank, apart from pin synchronisers and clear strobes
   typedef struct packed {
      logic [7:0] p0_dat, p0_dir, p1_dat, p1_dir, p3_dat, p3_dir;
      logic [7:0] p0_od, p1_od, p3_od;
      logic [7:0] tm0, t0_cmp, tm1, t1_per, t1_duty, t1_hi, tm2, t2_cmp;
      logic [7:0] buz, rps, smc, ssd, ieh, iel, iph, ipl, edge_sel;
      logic [7:0] cmc, crh, ckc, wdg, ssc, pfd, ps0, ps1, pu0, pu1, pu3;
      logic [7:0] rdata;
      logic rbad;
   } pcr_state_type;
endpackage

// ---- rtl/pcr_bank.sv ----
// Peripheral control register bank at data addresses 0xC0-0xFF.
// Assumes a CPU core on clk_sys giving single-cycle byte and bit strobes,
// and peripherals on the same clock supplying counts and event pulses.
//
// Notes on behaviour
// - Interval address: read count, write clock control
// - Read-write registers accept byte and bit ops
// - Reserved bits have no storage, read zero
// - Watchdog control write-only, reset 7F, clear bit
// - Watchdog address reads the watchdog counter
// - Timer2 write compare, read count or capture
// - Enable pair, one bit per source, reset zero
// - Pending flags mirror enable positions, read-write
// - Edge select two bits per external interrupt
// - RAM page field three bits, reset zero
// - Serial mode resets to 01 with fields
// - Serial shift data read-write, bit ops
// - Buzzer write-only, resets all ones
// - Converter mode resets to 01
// - Result high holds prescale, resolution, result bits
// - Clock control resets 17, bit 6 reserved
// - Stop/sleep write-only, byte only, reset zero
// - Power-fail enable, mode, status in 2:0
// - Pin function selects write-only, reset zero
// - Pull-up selects write-only, reset zero
`timescale 1ns/100ps
`default_nettype none
`include "pcr_cfg.svh"

module pcr_bank #(
   parameter int DW = 8
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire pcr_pkg::pcr_acc_type cpu_acc,
   input wire logic [2:0] cpu_bit_sel,
   input wire logic cpu_bit_val,
   input wire logic [DW-1:0] cpu_wdata,
   output logic [DW-1:0] cpu_rdata,
   output logic cpu_rd_unmapped,
   input wire logic [7:0] port0_pins,
   input wire logic [7:0] port1_pins,
   input wire logic [7:0] port3_pins,
   input wire logic [7:0] timer0_count,
   input wire logic [7:0] timer0_capture,
   input wire logic [7:0] timer1_count,
   input wire logic [7:0] timer1_capture,
   input wire logic [7:0] timer2_count,
   input wire logic [7:0] timer2_capture,
   input wire logic [7:0] interval_timer_count,
   input wire logic [7:0] watchdog_counter_reg,
   input wire logic [7:0] converter_result_low,
   input wire logic [4:0] converter_result_hi_bits,
   input wire logic [7:0] serial_shift_in,
   input wire logic serial_shift_load,
   input wire logic serial_done,
   input wire logic conversion_done,
   input wire logic power_fail_seen,
   input wire logic [7:0] irq_set_high,
   input wire logic [7:0] irq_set_low,
   output logic [7:0] irq_enable_high,
   output logic [7:0] irq_enable_low,
   output logic [7:0] irq_pending_high,
   output logic [7:0] irq_pending_low,
   output logic [7:0] ext_irq_edge_select,
   output logic [2:0] ram_page_select,
   output logic [7:0] serial_mode_ctrl,
   output logic [7:0] serial_shift_data,
   output logic [7:0] buzzer_ctrl,
   output logic [7:0] converter_mode_ctrl,
   output logic [2:0] converter_ctrl_hi,
   output logic [7:0] clock_control_reg,
   output logic [6:0] watchdog_compare,
   output logic watchdog_counter_clear,
   output logic interval_timer_clear,
   output logic [7:0] stop_sleep_ctrl,
   output logic [2:0] power_fail_detect_ctrl,
   output logic [6:0] pin_function_select_0,
   output logic [3:0] pin_function_select_1,
   output logic [7:0] port0_out,
   output logic [7:0] port0_dir,
   output logic [7:0] port1_out,
   output logic [7:0] port1_dir,
   output logic [7:0] port3_out,
   output logic [7:0] port3_dir,
   output logic [7:0] port0_od,
   output logic [7:0] port1_od,
   output logic [7:0] port3_od,
   output logic [7:0] timer0_mode,
   output logic [7:0] timer0_compare,
   output logic [7:0] timer1_mode,
   output logic [7:0] timer1_period,
   output logic [7:0] timer1_pwm_duty,
   output logic [3:0] timer1_pwm_hi,
   output logic [7:0] timer2_mode,
   output logic [7:0] timer2_compare,
   output logic [7:0] port0_pullup_select,
   output logic [7:0] port1_pullup_select,
   output logic [7:0] port3_pullup_select
);

   pcr_pkg::pcr_state_type st_q, st_d;
   logic [7:0] p0_s1_q, p0_s2_q, p1_s1_q, p1_s2_q, p3_s1_q, p3_s2_q;
   logic wd_clr_q, it_clr_q;

   // Byte or bit merge: bit ops touch one bit, byte ops the whole byte
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] mask);
      logic [7:0] v;
      v = old;
      if (cpu_acc == pcr_pkg::PCR_ACC_BIT) begin
         v[cpu_bit_sel] = cpu_bit_val;
      end else begin
         v = cpu_wdata[7:0];
      end
      return v & mask;
   endfunction

   // Write hit for a byte-only register; bit ops are dropped there
   function automatic logic byte_hit(input logic [7:0] a);
      return cpu_wr && cpu_addr == a &&
             cpu_acc == pcr_pkg::PCR_ACC_BYTE;
   endfunction

   function automatic logic rw_hit(input logic [7:0] a);
      return cpu_wr && cpu_addr == a;
   endfunction

   // Pins are asynchronous to clk_sys, so two stages before any use
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         p0_s1_q <= `PCR_R_ZERO;
         p0_s2_q <= `PCR_R_ZERO;
         p1_s1_q <= `PCR_R_ZERO;
         p1_s2_q <= `PCR_R_ZERO;
         p3_s1_q <= `PCR_R_ZERO;
         p3_s2_q <= `PCR_R_ZERO;
      end else begin
         p0_s1_q <= port0_pins;
         p0_s2_q <= p0_s1_q;
         p1_s1_q <= port1_pins;
         p1_s2_q <= p1_s1_q;
         p3_s1_q <= port3_pins;
         p3_s2_q <= p3_s1_q;
      end
   end

   // Next-state of the whole bank
   always_comb begin
      st_d = st_q;
      // Hardware event flags: set wins over a software clear
      if (rw_hit(`PCR_A_IPH)) begin
         st_d.iph = merge(st_q.iph, `PCR_M_IEH);
      end
      if (rw_hit(`PCR_A_IPL)) begin
         st_d.ipl = merge(st_q.ipl, `PCR_M_IEL);
      end
      st_d.iph = st_d.iph | (irq_set_high & `PCR_M_IEH);
      st_d.ipl = st_d.ipl | (irq_set_low & `PCR_M_IEL);
      if (rw_hit(`PCR_A_IEH)) st_d.ieh = merge(st_q.ieh, `PCR_M_IEH);
      if (rw_hit(`PCR_A_IEL)) st_d.iel = merge(st_q.iel, `PCR_M_IEL);
      if (rw_hit(`PCR_A_EDGE)) begin
         st_d.edge_sel = merge(st_q.edge_sel, `PCR_R_ONES);
      end
      if (rw_hit(`PCR_A_RPS)) st_d.rps = merge(st_q.rps, `PCR_M_RPS);
      if (rw_hit(`PCR_A_SMC)) begin
         st_d.smc = merge(st_q.smc, `PCR_R_ONES);
      end
      if (serial_done) st_d.smc[0] = 1'b1;
      if (rw_hit(`PCR_A_SSD)) begin
         st_d.ssd = merge(st_q.ssd, `PCR_R_ONES);
      end else if (serial_shift_load) begin
         st_d.ssd = serial_shift_in;
      end
      if (rw_hit(`PCR_A_CMC)) begin
         st_d.cmc = merge(st_q.cmc, `PCR_R_ONES);
      end
      if (conversion_done) st_d.cmc[0] = 1'b1;
      if (rw_hit(`PCR_A_CRH)) st_d.crh = merge(st_q.crh, `PCR_M_CRH);
      if (rw_hit(`PCR_A_PFD)) st_d.pfd = merge(st_q.pfd, `PCR_M_PFD);
      if (power_fail_seen) st_d.pfd[0] = 1'b1;
      if (rw_hit(`PCR_A_P0_DATA)) begin
         st_d.p0_dat = merge(st_q.p0_dat, `PCR_R_ONES);
      end
      if (rw_hit(`PCR_A_P1_DATA)) begin
         st_d.p1_dat = merge(st_q.p1_dat, `PCR_R_ONES);
      end
      if (rw_hit(`PCR_A_P3_DATA)) begin
         st_d.p3_dat = merge(st_q.p3_dat, `PCR_R_ONES);
      end
      if (rw_hit(`PCR_A_TM0)) st_d.tm0 = merge(st_q.tm0, `PCR_M_TMX);
      if (rw_hit(`PCR_A_TM1)) st_d.tm1 = merge(st_q.tm1, `PCR_R_ONES);
      if (rw_hit(`PCR_A_TM2)) st_d.tm2 = merge(st_q.tm2, `PCR_M_TMX);
      // Byte-only registers
      if (byte_hit(`PCR_A_P0_DIR)) st_d.p0_dir = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_P1_DIR)) st_d.p1_dir = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_P3_DIR)) st_d.p3_dir = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_P0_OD)) st_d.p0_od = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_P1_OD)) st_d.p1_od = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_P3_OD)) st_d.p3_od = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_T0)) st_d.t0_cmp = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_T1PER)) st_d.t1_per = cpu_wdata[7:0];
      // Duty register is write-only (its address reads timer1 count or capture) and takes whole bytes only
      if (byte_hit(`PCR_A_T1)) st_d.t1_duty = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_T1HI)) st_d.t1_hi = cpu_wdata[7:0] & `PCR_M_T1HI;
      if (byte_hit(`PCR_A_T2)) st_d.t2_cmp = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_BUZ)) st_d.buz = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_ICK)) begin
         st_d.ckc = cpu_wdata[7:0] & `PCR_M_CKC;
      end
      if (byte_hit(`PCR_A_WDG)) st_d.wdg = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_SSC)) st_d.ssc = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_PS0)) begin
         st_d.ps0 = cpu_wdata[7:0] & `PCR_M_PS0;
      end
      if (byte_hit(`PCR_A_PS1)) st_d.ps1 = cpu_wdata[7:0] & `PCR_M_PS1;
      if (byte_hit(`PCR_A_PU0)) st_d.pu0 = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_PU1)) st_d.pu1 = cpu_wdata[7:0];
      if (byte_hit(`PCR_A_PU3)) st_d.pu3 = cpu_wdata[7:0];
      // Read mux; registered so data leaves from flip-flops
      st_d.rbad = 1'b0;
      st_d.rdata = `PCR_R_ZERO;
      if (cpu_rd) begin
         case (cpu_addr)
            `PCR_A_P0_DATA: st_d.rdata = p0_s2_q;
            `PCR_A_P1_DATA: st_d.rdata = p1_s2_q;
            `PCR_A_P3_DATA: st_d.rdata = p3_s2_q;
            `PCR_A_TM0: st_d.rdata = st_q.tm0;
            `PCR_A_TM1: st_d.rdata = st_q.tm1;
            `PCR_A_TM2: st_d.rdata = st_q.tm2;
            `PCR_A_T0: st_d.rdata = st_q.tm0[`PCR_B_CAP02] ?
                                    timer0_capture : timer0_count;
            `PCR_A_T1: st_d.rdata = st_q.tm1[`PCR_B_CAP1] ?
                                    timer1_capture : timer1_count;
            `PCR_A_T2: st_d.rdata = st_q.tm2[`PCR_B_CAP02] ?
                                    timer2_capture : timer2_count;
            `PCR_A_RPS: st_d.rdata = st_q.rps;
            `PCR_A_SMC: st_d.rdata = st_q.smc;
            `PCR_A_SSD: st_d.rdata = st_q.ssd;
            `PCR_A_IEH: st_d.rdata = st_q.ieh;
            `PCR_A_IEL: st_d.rdata = st_q.iel;
            `PCR_A_IPH: st_d.rdata = st_q.iph;
            `PCR_A_IPL: st_d.rdata = st_q.ipl;
            `PCR_A_EDGE: st_d.rdata = st_q.edge_sel;
            `PCR_A_CMC: st_d.rdata = st_q.cmc;
            `PCR_A_CRH: st_d.rdata = st_q.crh |
                                     {3'b000, converter_result_hi_bits};
            `PCR_A_CRL: st_d.rdata = converter_result_low;
            `PCR_A_ICK: st_d.rdata = interval_timer_count;
            `PCR_A_WDG: st_d.rdata = watchdog_counter_reg;
            `PCR_A_PFD: st_d.rdata = st_q.pfd;
            default: st_d.rdata = `PCR_R_ZERO;
         endcase
         // Write-only and unoccupied addresses read zero and are flagged
         case (cpu_addr)
            `PCR_A_P0_DATA, `PCR_A_P1_DATA, `PCR_A_P3_DATA, `PCR_A_TM0,
            `PCR_A_TM1, `PCR_A_TM2, `PCR_A_T0, `PCR_A_T1, `PCR_A_T2,
            `PCR_A_RPS, `PCR_A_SMC, `PCR_A_SSD, `PCR_A_IEH, `PCR_A_IEL,
            `PCR_A_IPH, `PCR_A_IPL, `PCR_A_EDGE, `PCR_A_CMC, `PCR_A_CRH,
            `PCR_A_CRL, `PCR_A_ICK, `PCR_A_WDG, `PCR_A_PFD: st_d.rbad = 1'b0;
            default: st_d.rbad = 1'b1;
         endcase
      end
   end

   // State register; serial shift data has no defined reset, zero chosen
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.t0_cmp <= `PCR_R_ONES;
         st_q.t1_per <= `PCR_R_ONES;
         st_q.t2_cmp <= `PCR_R_ONES;
         st_q.buz <= `PCR_R_ONES;
         st_q.smc <= `PCR_R_SMC;
         st_q.cmc <= `PCR_R_CMC;
         st_q.ckc <= `PCR_R_CKC;
         st_q.wdg <= `PCR_R_WDG;
      end else begin
         st_q <= st_d;
      end
   end

   // Clear strobes: one-cycle pulses on a byte write with the bit set
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wd_clr_q <= 1'b0;
         it_clr_q <= 1'b0;
      end else begin
         wd_clr_q <= byte_hit(`PCR_A_WDG) && cpu_wdata[`PCR_B_WDCLR];
         it_clr_q <= byte_hit(`PCR_A_ICK) && cpu_wdata[`PCR_B_ITCLR];
      end
   end

   // Outputs
   assign cpu_rdata = st_q.rdata;
   assign cpu_rd_unmapped = st_q.rbad;
   assign irq_enable_high = st_q.ieh;
   assign irq_enable_low = st_q.iel;
   assign irq_pending_high = st_q.iph;
   assign irq_pending_low = st_q.ipl;
   assign ext_irq_edge_select = st_q.edge_sel;
   assign ram_page_select = st_q.rps[2:0];
   assign serial_mode_ctrl = st_q.smc;
   assign serial_shift_data = st_q.ssd;
   assign buzzer_ctrl = st_q.buz;
   assign converter_mode_ctrl = st_q.cmc;
   assign converter_ctrl_hi = st_q.crh[7:5];
   assign clock_control_reg = st_q.ckc;
   assign watchdog_compare = st_q.wdg[6:0];
   assign watchdog_counter_clear = wd_clr_q;
   assign interval_timer_clear = it_clr_q;
   assign stop_sleep_ctrl = st_q.ssc;
   assign power_fail_detect_ctrl = st_q.pfd[2:0];
   assign pin_function_select_0 = st_q.ps0[6:0];
   assign pin_function_select_1 = st_q.ps1[3:0];
   assign port0_out = st_q.p0_dat;
   assign port0_dir = st_q.p0_dir;
   assign port1_out = st_q.p1_dat;
   assign port1_dir = st_q.p1_dir;
   assign port3_out = st_q.p3_dat;
   assign port3_dir = st_q.p3_dir;
   assign port0_od = st_q.p0_od;
   assign port1_od = st_q.p1_od;
   assign port3_od = st_q.p3_od;
   assign timer0_mode = st_q.tm0;
   assign timer0_compare = st_q.t0_cmp;
   assign timer1_mode = st_q.tm1;
   assign timer1_period = st_q.t1_per;
   assign timer1_pwm_duty = st_q.t1_duty;
   assign timer1_pwm_hi = st_q.t1_hi[3:0];
   assign timer2_mode = st_q.tm2;
   assign timer2_compare = st_q.t2_cmp;
   assign port0_pullup_select = st_q.pu0;
   assign port1_pullup_select = st_q.pu1;
   assign port3_pullup_select = st_q.pu3;

   // Checks
   sequence s_wd_write;
      byte_hit(`PCR_A_WDG) && cpu_wdata[`PCR_B_WDCLR];
   endsequence

   a_wd_clear_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_wd_write ##1 !(byte_hit(`PCR_A_WDG) && cpu_wdata[`PCR_B_WDCLR])
      |-> watchdog_counter_clear ##1 !watchdog_counter_clear)
      else $error("watchdog clear pulse wrong");
   // Interval clear pulses exactly for one cycle after a write with the bit
   a_it_clear_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      interval_timer_clear ==
      $past(byte_hit(`PCR_A_ICK) && cpu_wdata[`PCR_B_ITCLR]))
      else $error("interval clear pulse wrong");
   a_wd_read_counter: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cpu_rd && cpu_addr == `PCR_A_WDG
      |=> cpu_rdata == $past(watchdog_counter_reg))
      else $error("watchdog read not counter");
   a_interval_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cpu_rd && cpu_addr == `PCR_A_ICK
      |=> cpu_rdata == $past(interval_timer_count))
      else $error("interval read wrong");
   a_ckc_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
      byte_hit(`PCR_A_ICK)
      |=> clock_control_reg == ($past(cpu_wdata) & `PCR_M_CKC))
      else $error("clock control write lost");
   a_t2_capture_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cpu_rd && cpu_addr == `PCR_A_T2 && timer2_mode[`PCR_B_CAP02]
      |=> cpu_rdata == $past(timer2_capture))
      else $error("timer2 capture not selected");
   a_pend_set_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (irq_set_high & `PCR_M_IEH) != 8'h00 |=>
      (irq_pending_high & $past(irq_set_high & `PCR_M_IEH)) ==
      $past(irq_set_high & `PCR_M_IEH))
      else $error("pending flag lost");
   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (irq_enable_high & ~`PCR_M_IEH) == 8'h00 &&
      (clock_control_reg & ~`PCR_M_CKC) == 8'h00 &&
      (st_q.rps & ~`PCR_M_RPS) == 8'h00)
      else $error("reserved bit stored");
   a_byte_only_bitop: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cpu_wr && cpu_addr == `PCR_A_BUZ && cpu_acc == pcr_pkg::PCR_ACC_BIT
      |=> $stable(buzzer_ctrl))
      else $error("bit op changed byte-only");
   a_bit_op_one: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cpu_wr && cpu_addr == `PCR_A_EDGE && cpu_acc == pcr_pkg::PCR_ACC_BIT
      |=> ext_irq_edge_select[$past(cpu_bit_sel)] == $past(cpu_bit_val))
      else $error("bit op not applied");

endmodule
`default_nettype wire

// ---- test/pcr_cpu_model.sv ----
// CPU core stand-in issuing byte and bit accesses to the register bank.
// Assumes clk_sys is free running; strobes move 1 ns after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module pcr_cpu_model (
   input wire logic clk_sys,
   output logic [7:0] cpu_addr,
   output logic cpu_wr,
   output logic cpu_rd,
   output pcr_pkg::pcr_acc_type cpu_acc,
   output logic [2:0] cpu_bit_sel,
   output logic cpu_bit_val,
   output logic [7:0] cpu_wdata
);
   // Idle bus at time zero
   initial begin
      cpu_addr = 8'h00;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      cpu_acc = pcr_pkg::PCR_ACC_BYTE;
      cpu_bit_sel = 3'h0;
      cpu_bit_val = 1'b0;
      cpu_wdata = 8'h00;
   end
   // One access held over its taking edge; released address and write data show inverses
   // so a stale value is never mistaken for a held one
   task automatic xfer(input logic [7:0] a, input logic w, input logic bt,
                       input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      cpu_addr = a;
      cpu_wr = w;
      cpu_rd = !w;
      cpu_acc = bt ? pcr_pkg::PCR_ACC_BIT : pcr_pkg::PCR_ACC_BYTE;
      cpu_bit_sel = d[2:0];
      cpu_bit_val = d[3];
      cpu_wdata = d;
      @(posedge clk_sys);
      #1;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      cpu_addr = ~a;
      cpu_wdata = ~d;
   endtask
   // Whole-byte writes, the only kind that byte-only registers take
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, 1'b0, d);
   endtask
   task automatic bop(input logic [7:0] a, input logic [2:0] b,
                      input logic v);
      xfer(a, 1'b1, 1'b1, {4'h0, v, b});
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(a, 1'b0, 1'b0, 8'h00);
   endtask
endmodule
`default_nettype wire

// ---- test/peripheral_control_register_map_tb.sv ----
// Self-checking bench for the control register bank.
// Assumes pcr_pkg compiled first and pcr_cfg.svh on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "pcr_cfg.svh"
module peripheral_control_register_map_tb;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [127:0] rnd = '0;
   logic ev = 1'b0;
   logic [7:0] ish = 8'h00;
   logic [7:0] a, wd, d, ckc, t2cmp, buz, smc, ssd, cmc, ieh, iph, ipl;
   logic [7:0] ssc, pu0, duty, rdat, edg, ph, iel;
   logic [6:0] wdcmp, ps0;
   logic [3:0] ps1;
   logic [2:0] rps, pfd, chi;
   logic wr, rd, bsv, unm, wclr, itc, rd_seen = 1'b0;
   logic [2:0] bsel;
   pcr_pkg::pcr_acc_type acc;
   logic [8:0] note;
   logic [8:0] exq[$];
   logic [15:0] tbl[8];
   int err_count = 0;
   int samples_checked = 0;
   always #2.5 clk_sys = ~clk_sys;
   pcr_cpu_model cpu (.clk_sys(clk_sys), .cpu_addr(a), .cpu_wr(wr),
      .cpu_rd(rd), .cpu_acc(acc), .cpu_bit_sel(bsel), .cpu_bit_val(bsv),
      .cpu_wdata(wd));
   // Peripheral values come from one random word; events share one pulse
   pcr_bank #(.DW(8)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
      .cpu_addr(a), .cpu_wr(wr), .cpu_rd(rd), .cpu_acc(acc),
      .cpu_bit_sel(bsel), .cpu_bit_val(bsv), .cpu_wdata(wd),
      .cpu_rdata(rdat), .cpu_rd_unmapped(unm), .port0_pins(rnd[7:0]),
      .port1_pins(rnd[15:8]), .port3_pins(rnd[23:16]),
      .timer0_count(rnd[31:24]), .timer0_capture(rnd[39:32]),
      .timer1_count(rnd[47:40]), .timer1_capture(rnd[55:48]),
      .timer2_count(rnd[63:56]), .timer2_capture(rnd[71:64]),
      .interval_timer_count(rnd[79:72]), .watchdog_counter_reg(rnd[87:80]),
      .converter_result_low(rnd[95:88]),
      .converter_result_hi_bits(rnd[100:96]), .serial_shift_in(rnd[111:104]),
      .serial_shift_load(ev), .serial_done(ev), .conversion_done(ev),
      .power_fail_seen(ev), .irq_set_high(ish), .irq_set_low(ish),
      .irq_enable_high(ieh), .irq_enable_low(iel), .irq_pending_high(iph),
      .irq_pending_low(ipl), .ext_irq_edge_select(edg), .ram_page_select(rps),
      .serial_mode_ctrl(smc), .serial_shift_data(ssd), .buzzer_ctrl(buz),
      .converter_mode_ctrl(cmc), .converter_ctrl_hi(chi),
      .clock_control_reg(ckc), .watchdog_compare(wdcmp),
      .watchdog_counter_clear(wclr), .interval_timer_clear(itc),
      .stop_sleep_ctrl(ssc), .power_fail_detect_ctrl(pfd),
      .pin_function_select_0(ps0), .pin_function_select_1(ps1),
      .port0_out(), .port0_dir(), .port1_out(), .port1_dir(), .port3_out(),
      .port3_dir(), .port0_od(), .port1_od(), .port3_od(), .timer0_mode(),
      .timer0_compare(), .timer1_mode(), .timer1_period(),
      .timer1_pwm_duty(duty), .timer1_pwm_hi(), .timer2_mode(),
      .timer2_compare(t2cmp), .port0_pullup_select(pu0),
      .port1_pullup_select(), .port3_pullup_select());
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdx(input logic [7:0] ad, input logic [8:0] e);
      exq.push_back(e);
      cpu.rd(ad);
   endtask
   task automatic conclude();
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Read data stands in the cycle after the taking edge; look mid-cycle
   always @(posedge clk_sys) rd_seen <= rd;
   always @(negedge clk_sys) begin
      if (rd_seen) begin
         note = exq.pop_front();
         chk("rdata", note[7:0], rdat);
         chk("unmapped", 8'(note[8]), 8'(unm));
      end
   end
   // Hang guard, far beyond the roughly one hundred cycles the tests need
   initial begin
      #20000;
      err_count++;
      conclude();
   end
   initial begin
      void'($urandom(87274));
      rnd = {$urandom, $urandom, $urandom, $urandom};
      // Address and implemented-bit mask of read-write registers
      tbl = '{16'hE1_07, 16'hEA_F3, 16'hEB_CD, 16'hEC_F3, 16'hED_CD,
              16'hEE_FF, 16'hE3_FF, 16'hF7_07};
      repeat (3) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      chk("buzzer", 8'hFF, buz);
      chk("serial mode", 8'h01, smc);
      chk("conv mode", 8'h01, cmc);
      chk("clock ctrl", 8'h17, ckc);
      chk("wd compare", 8'h7F, 8'(wdcmp));
      chk("t2 compare", 8'hFF, t2cmp);
      chk("enables", 8'h00, ieh);
      chk("enables lo", 8'h00, iel);
      chk("pending", 8'h00, iph);
      chk("edge sel", 8'h00, edg);
      chk("page", 8'h00, 8'(rps));
      chk("stop sleep", 8'h00, ssc);
      chk("pfd", 8'h00, 8'(pfd));
      chk("psel0", 8'h00, 8'(ps0));
      chk("pullup0", 8'h00, pu0);
      // Shared interval address: write control, read count
      d = 8'($urandom);
      cpu.wr(`PCR_A_ICK, d);
      chk("clock ctrl", d & 8'hBF, ckc);
      chk("interval clear", 8'(d[3]), 8'(itc));
      rdx(`PCR_A_ICK, {1'b0, rnd[79:72]});
      // Watchdog clear pulses once; reads give the counter
      cpu.wr(`PCR_A_WDG, 8'h80);
      chk("wd clear", 8'h01, 8'(wclr));
      chk("wd compare", 8'h00, 8'(wdcmp));
      rdx(`PCR_A_WDG, {1'b0, rnd[87:80]});
      chk("wd clear", 8'h00, 8'(wclr));
      // Timer2 compare, then count or capture by mode bit; timer0 count and timer1 capture reads
      cpu.wr(`PCR_A_T2, d);
      chk("t2 compare", d, t2cmp);
      cpu.wr(`PCR_A_TM2, 8'h00);
      rdx(`PCR_A_T2, {1'b0, rnd[63:56]});
      cpu.bop(`PCR_A_TM2, 3'd5, 1'b1);
      rdx(`PCR_A_T2, {1'b0, rnd[71:64]});
      rdx(`PCR_A_T0, {1'b0, rnd[31:24]});
      cpu.wr(`PCR_A_TM1, 8'h10);
      rdx(`PCR_A_T1, {1'b0, rnd[55:48]});
      // Bit ops land on read-write registers, ignored on byte-only ones
      cpu.bop(`PCR_A_IEH, 3'd0, 1'b1);
      chk("enables", 8'h01, ieh);
      cpu.bop(`PCR_A_EDGE, 3'd6, 1'b1);
      chk("edge sel", 8'h40, edg);
      cpu.bop(`PCR_A_BUZ, 3'd0, 1'b0);
      chk("buzzer", 8'hFF, buz);
      cpu.bop(`PCR_A_SSC, 3'd2, 1'b1);
      chk("stop sleep", 8'h00, ssc);
      cpu.bop(`PCR_A_PU0, 3'd1, 1'b1);
      chk("pullup0", 8'h00, pu0);
      cpu.bop(`PCR_A_T1, 3'd3, 1'b1);
      chk("pwm duty", 8'h00, duty);
      // Reserved bits forced high on write must read back zero
      foreach (tbl[i]) begin
         d = 8'($urandom);
         cpu.wr(tbl[i][15:8], d | ~tbl[i][7:0]);
         rdx(tbl[i][15:8], {1'b0, d & tbl[i][7:0]});
      end
      // Write-only and unused places read zero and flag it; then converter result reads and pin select masks
      rdx(`PCR_A_BUZ, 9'h100);
      rdx(`PCR_A_SSC, 9'h100);
      rdx(8'hC4, 9'h100);
      cpu.wr(`PCR_A_CRH, 8'hFF);
      chk("conv hi ctrl", 8'h07, 8'(chi));
      rdx(`PCR_A_CRH, {4'h7, rnd[100:96]});
      rdx(`PCR_A_CRL, {1'b0, rnd[95:88]});
      cpu.wr(`PCR_A_PS0, 8'hFF);
      chk("psel0", 8'h7F, 8'(ps0));
      cpu.wr(`PCR_A_PS1, 8'hFF);
      chk("psel1", 8'h0F, 8'(ps1));
      // Status flags, pending bits and shift data set by peripheral pulses
      cpu.wr(`PCR_A_SMC, 8'h00);
      cpu.wr(`PCR_A_CMC, 8'h00);
      cpu.wr(`PCR_A_PFD, 8'h00);
      cpu.wr(`PCR_A_IPH, 8'h00);
      cpu.wr(`PCR_A_IPL, 8'h00);
      ph = 8'($urandom);
      @(posedge clk_sys);
      #1;
      ev = 1'b1;
      ish = ph;
      @(posedge clk_sys);
      #1;
      ev = 1'b0;
      ish = 8'h00;
      chk("serial mode", 8'h01, smc);
      chk("conv mode", 8'h01, cmc);
      chk("pfd", 8'h01, 8'(pfd));
      chk("shift data", rnd[111:104], ssd);
      chk("pending hi", ph & 8'hF3, iph);
      chk("pending lo", ph & 8'hCD, ipl);
      repeat (2) @(posedge clk_sys);
      conclude();
   end
endmodule
`default_nettype wire
